// ==== dv/dual_timer_monitor.sv ====
// *****
// Dual timer checks
// *****
module dual_timer_monitor
   import dual_timer_pkg::*;
(
   input wire logic        ref_clk,
   input wire logic        rst,
   input wire logic        awvalid,
   input wire logic        awready,
   input wire logic        wvalid,
   input wire logic        wready,
   input wire logic        bvalid,
   input wire logic        arvalid,
   input wire logic        arready,
   input wire logic [31:0] rdata,
   input wire logic        rvalid,
   input wire logic        rready,
   input wire logic        timerInputPin,
   input wire logic [7:0]  port3Out,
   input wire logic        inputEdgeRequest,
   input wire logic        firstCounterDoneRequest,
   input wire logic        secondCounterDoneRequest
);
   timeunit 1ns;
   timeprecision 1ps;

   // Idle while reset is high
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (rst);

   // Bus handshake steps
   sequence s_write_taken;
      awvalid && awready && wvalid && wready;
   endsequence
   sequence s_read_taken;
      arvalid && arready;
   endsequence

   a_write_answer: assert property (s_write_taken |-> ##[1:3] bvalid)
      else $error("no write answer");
   a_read_answer: assert property (s_read_taken |=> rvalid && !arready)
      else $error("no read data");
   a_read_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
      else $error("read data dropped");
   a_read_upper: assert property (rvalid |-> rdata[31:8] == 24'h000000)
      else $error("upper read bits set");
   a_edge_after_fall: assert property ($fell(timerInputPin) |-> ##[1:4] inputEdgeRequest)
      else $error("edge request missing");
   a_edge_single: assert property (inputEdgeRequest |=> !inputEdgeRequest)
      else $error("edge request too long");
   a_first_spacing: assert property (firstCounterDoneRequest |=> !firstCounterDoneRequest [*3])
      else $error("first ends too close");
   a_second_single: assert property (secondCounterDoneRequest |=> !secondCounterDoneRequest)
      else $error("second request too long");
   a_port_reset: assert property ($fell(rst) |-> port3Out == PORT3_RST)
      else $error("port reset wrong");
endmodule : dual_timer_monitor

bind dual_timer_counter dual_timer_monitor mon (.ref_clk, .rst, .awvalid, .awready, .wvalid,
   .wready, .bvalid, .arvalid, .arready, .rdata, .rvalid, .rready, .timerInputPin, .port3Out,
   .inputEdgeRequest, .firstCounterDoneRequest, .secondCounterDoneRequest);

// ==== dv/event_source.sv ====
// *****
// Input pin source
// *****
module event_source
(
   input wire logic ref_clk,
   output logic     pin
);
   timeunit 1ns;
   timeprecision 1ps;

   // Idle high; phases of two clocks or more
   initial pin = 1'b1;

   task automatic pulse(input int lowCyc, input int highCyc);
      @(posedge ref_clk);
      pin <= 1'b0;
      repeat (lowCyc) @(posedge ref_clk);
      pin <= 1'b1;
      repeat (highCyc) @(posedge ref_clk);
   endtask : pulse

   task automatic level(input logic v);
      @(posedge ref_clk);
      pin <= v;
   endtask : level
endmodule : event_source

// ==== dv/tb.sv ====
// *****
// Dual timer bench
// *****
module tb
   import dual_timer_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   logic              ref_clk = 1'b0;
   logic              rst = 1'b1;
   logic [ADDR_W-1:0] awaddr = '0;
   logic              awvalid = 1'b0;
   logic [31:0]       wdata = '0;
   logic [3:0]        wstrb = '0;
   logic              wvalid = 1'b0;
   logic              bready = 1'b0;
   logic [ADDR_W-1:0] araddr = '0;
   logic              arvalid = 1'b0;
   logic              rready = 1'b0;
   logic              awready, wready, bvalid, arready, rvalid;
   logic [1:0]        bresp, rresp;
   logic [31:0]       rdata;
   logic              timerInputPin;
   logic [7:0]        port3Out;
   logic              inputEdgeRequest, firstCounterDoneRequest, secondCounterDoneRequest;
   int                n_errors = 0;
   int                cmp_count = 0;

   dual_timer_counter dut (.ref_clk, .rst, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
      .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
      .rready, .timerInputPin, .port3Out, .inputEdgeRequest, .firstCounterDoneRequest,
      .secondCounterDoneRequest);
   event_source src (.ref_clk, .pin(timerInputPin));

   // 40 MHz clock
   always #12.5 ref_clk = ~ref_clk;

   task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
      cmp_count++;
      if (got !== exp)
      begin
         n_errors++;
         $display("Error %s expected %0h seen %0h", nm, exp, got);
      end
   endtask : check

   // Write: aw and w together, each dropped when taken
   task automatic wr(input logic [7:0] idx, input logic [7:0] d, input logic [3:0] st = 4'h1);
      logic aDone = 1'b0;
      logic wDone = 1'b0;
      @(posedge ref_clk);
      awaddr <= {2'b00, idx, 2'b00};
      wdata <= {24'h000000, d};
      wstrb <= st;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      while (!(aDone && wDone))
      begin
         @(posedge ref_clk);
         aDone = aDone || awready;
         wDone = wDone || wready;
         awvalid <= !aDone;
         wvalid <= !wDone;
      end
      bready <= 1'b1;
      do @(posedge ref_clk); while (!bvalid);
      check("bresp", {30'h0, RESP_OKAY}, {30'h0, bresp});
      bready <= 1'b0;
   endtask : wr

   // Read and judge data and response
   task automatic rdchk(input string nm, input logic [7:0] idx, input logic [31:0] exp,
                        input logic [1:0] er);
      @(posedge ref_clk);
      araddr <= {2'b00, idx, 2'b00};
      arvalid <= 1'b1;
      do @(posedge ref_clk); while (!arready);
      arvalid <= 1'b0;
      rready <= 1'b1;
      do @(posedge ref_clk); while (!rvalid);
      rready <= 1'b0;
      check(nm, exp, rdata);
      check({nm, " resp"}, {30'h0, er}, {30'h0, rresp});
   endtask : rdchk

   // Request pulses in a window
   task automatic watch(input int n, output int c1, output int c2, output int ce);
      c1 = 0;
      c2 = 0;
      ce = 0;
      repeat (n)
      begin
         @(posedge ref_clk);
         c1 += firstCounterDoneRequest;
         c2 += secondCounterDoneRequest;
         ce += inputEdgeRequest;
      end
   endtask : watch

   task automatic burst(input int np, input int n, output int c1, output int c2, output int ce);
      fork
         repeat (np) src.pulse(3, 4);
         watch(n, c1, c2, ce);
      join
   endtask : burst

   // Bounded wait for the next first request
   task automatic gap(output int g);
      g = 0;
      do
      begin
         @(posedge ref_clk);
         g++;
      end
      while (!firstCounterDoneRequest && g < 3000);
   endtask : gap

   task automatic t_regs();
      rdchk("mode reset", IDX_MODE, 32'hC0, RESP_OKAY);
      rdchk("port reset", IDX_PORT3, 32'hFF, RESP_OKAY);
      wr(IDX_FIRST_PRE, 8'hFF);
      rdchk("prescaler read", IDX_FIRST_PRE, 32'h0, RESP_OKAY);
      wr(IDX_SECOND_CNT, 8'h55, 4'h0);
      rdchk("strobe off", IDX_SECOND_CNT, 32'h0, RESP_OKAY);
      rdchk("unmapped", 8'h10, 32'h0, RESP_SLVERR);
      $display("test regs done");
   endtask : t_regs

   task automatic t_first();
      logic [7:0] pre [3] = '{8'h0B, 8'h03, 8'h07};
      logic [7:0] cnt [3] = '{8'h03, 8'h01, 8'h00};
      int         span [3] = '{24, 256, 1024};
      int         g, c1, c2, ce, flips;
      logic       lvl;
      // Continuous intervals, zero loads as maximum
      for (int i = 0; i < 3; i++)
      begin
         wr(IDX_FIRST_PRE, pre[i]);
         wr(IDX_FIRST_CNT, cnt[i]);
         wr(IDX_MODE, 8'h03);
         @(posedge ref_clk);
         check("pin after load", 32'h1, port3Out[6]);
         repeat (3) @(posedge ref_clk);
         gap(g);
         gap(g);
         check("interval", span[i], g);
         repeat (2) @(posedge ref_clk);
         lvl = port3Out[6];
         gap(g);
         repeat (2) @(posedge ref_clk);
         check("pin toggle", {31'h0, !lvl}, port3Out[6]);
      end
      wr(IDX_MODE, 8'h01);
      wr(IDX_PORT3, 8'h00);
      @(posedge ref_clk);
      check("port pin", 32'h40, port3Out);
      rdchk("port read", IDX_PORT3, 32'h40, RESP_OKAY);
      wr(IDX_FIRST_PRE, 8'h06);
      wr(IDX_FIRST_CNT, 8'h02);
      wr(IDX_MODE, 8'h03);
      watch(200, c1, c2, ce);
      check("single pass", 32'd1, c1);
      wr(IDX_MODE, 8'h80);
      repeat (2) @(posedge ref_clk);
      flips = 0;
      lvl = port3Out[6];
      repeat (8)
      begin
         @(posedge ref_clk);
         flips += (port3Out[6] != lvl);
         lvl = port3Out[6];
      end
      check("clock out", 32'd8, flips);
      $display("test first done");
   endtask : t_first

   task automatic t_second();
      int c1, c2, ce;
      wr(IDX_SECOND_PRE, 8'h05);
      wr(IDX_SECOND_CNT, 8'h03);
      wr(IDX_MODE, 8'h4C);
      burst(6, 60, c1, c2, ce);
      check("event ends", 32'd2, c2);
      check("edge requests", 32'd6, ce);
      wr(IDX_MODE, 8'h1C);
      src.level(1'b0);
      watch(80, c1, c2, ce);
      check("gate closed", 32'd0, c2);
      check("gate edge", 32'd1, ce);
      src.level(1'b1);
      watch(60, c1, c2, ce);
      check("gate open", 32'd1, c2 >= 4);
      wr(IDX_SECOND_PRE, 8'h04);
      wr(IDX_SECOND_CNT, 8'h05);
      wr(IDX_MODE, 8'h2C);
      watch(60, c1, c2, ce);
      check("armed idle", 32'd0, c2);
      burst(1, 60, c1, c2, ce);
      check("one shot", 32'd1, c2);
      rdchk("enable cleared", IDX_MODE, 32'h20, RESP_OKAY);
      burst(1, 60, c1, c2, ce);
      check("ignored edge", 32'd0, c2);
      wr(IDX_SECOND_PRE, 8'h05);
      wr(IDX_MODE, 8'h2C);
      burst(10, 100, c1, c2, ce);
      check("later edges", 32'd1, c2 >= 4);
      wr(IDX_MODE, 8'h3C);
      burst(10, 80, c1, c2, ce);
      check("retrigger hold", 32'd0, c2);
      watch(50, c1, c2, ce);
      check("retrigger ends", 32'd2, c2);
      wr(IDX_MODE, 8'hC0);
      $display("test second done");
   endtask : t_second

   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : give_verdict

   // Main sequence after a three-cycle reset
   initial
   begin
      repeat (3) @(posedge ref_clk);
      rst <= 1'b0;
      t_regs();
      t_first();
      t_second();
      give_verdict();
   end

   // Watchdog, about four times the run
   initial
   begin
      repeat (20000) @(posedge ref_clk);
      n_errors++;
      $display("Error watchdog expected finish seen hang");
      give_verdict();
   end
endmodule : tb

// ==== logic/dual_timer_counter.sv ====
// How it works
// - Two 8-bit counters, each behind a 6-bit prescaler fed at clock/4, except the second in external clock mode.
// - Single-pass halts at end-of-count; continuous reloads and keeps counting.
// - Load values writable while running; load bit applies at once, else at end.
// - Prescaler registers are write-only; reads return zero.
// - Prescale 1-64, count 1-256; a zero load means the maximum.
// - Internal interval is four clocks times prescale times count.
// - External clock bypasses the divider; end after prescale times count events.
// - Port 3 bit 6 can output either counter toggle or internal clock.
// - Selected counter's load bit forces the pin high; each end toggles it.
// - Internal clock selection drives the clock out on the pin.
// - Port writes reach the timer pin only when its output is switched off; reads return its level.
// - Port 3 bit 1 feeds second counter: clock, gate, one-shot, retrigger.
// - Trigger modes start counting two to three clocks after falling edge.
// - Every input falling edge raises the input-edge request, always.
// - External clock mode counts falling edges; request on the nth.
// - Gate mode prescales internal clock only while the input is high.
// - One-shot mode loads on first edge after enable; later edges ignored.
// - Trigger single-pass end clears enable; edges ignored until re-enabled.
// - Trigger continuous end keeps enable, reloads, and requests every end.
// - Retrigger mode reloads on every edge; ends only after full quiet interval.
// - Mode load and enable bits start second counter; prescale bits pick mode.
//
// Chosen here: the AXI4-Lite register port.
module dual_timer_counter
   import dual_timer_pkg::*;
(
   input  wire logic              ref_clk,
   input  wire logic              rst,
   input  wire logic [ADDR_W-1:0] awaddr,
   input  wire logic              awvalid,
   output logic                   awready,
   input  wire logic [31:0]       wdata,
   input  wire logic [3:0]        wstrb,
   input  wire logic              wvalid,
   output logic                   wready,
   output logic [1:0]             bresp,
   output logic                   bvalid,
   input  wire logic              bready,
   input  wire logic [ADDR_W-1:0] araddr,
   input  wire logic              arvalid,
   output logic                   arready,
   output logic [31:0]            rdata,
   output logic [1:0]             rresp,
   output logic                   rvalid,
   input  wire logic              rready,
   input  wire logic              timerInputPin,
   output logic [7:0]             port3Out,
   output logic                   inputEdgeRequest,
   output logic                   firstCounterDoneRequest,
   output logic                   secondCounterDoneRequest
);

   // ***********************************************
   // Declarations
   // ***********************************************
   top_state_s st;
   top_state_s next_st;
   chan_cfg_s  firstCfg;
   chan_cfg_s  secondCfg;
   logic [7:0] firstCount;
   logic [7:0] secondCount;
   logic       firstEoc;
   logic       secondEoc;
   logic       tinLevel;
   logic       tinFall;
   logic       prescTick;
   logic       extSrc;
   tin_mode_e  tinMode;
   timer_output_pin_sel_e  toutSel;
   logic       trigMode;
   logic       trigLoad;
   logic       secondLoadNow;
   logic       firstRun;
   logic       secondRun;
   logic       secondTick;

   // ***********************************************
   // Address decode helpers
   // ***********************************************
   // Aligned, within 256 words
   function automatic logic addrOk(input logic [ADDR_W-1:0] a);
      addrOk = (a[1:0] == 2'h0) && (a[ADDR_W-1:10] == '0);
   endfunction : addrOk

   // Read view; bit 8 flags unknown index
   function automatic logic [8:0] readReg(input logic [7:0] idx,
                                          input top_state_s s,
                                          input logic [7:0] c0,
                                          input logic [7:0] c1);
      logic [8:0] r;
      r = {1'b0, 8'h00};
      if (idx == IDX_MODE)
         r = {1'b0, s.mode};
      else if (idx == IDX_FIRST_CNT)
         r = {1'b0, c0};
      else if (idx == IDX_SECOND_CNT)
         r = {1'b0, c1};
      else if (idx == IDX_FIRST_PRE || idx == IDX_SECOND_PRE)
         r = {1'b0, 8'h00};
      else if (idx == IDX_PORT3)
         r = {1'b0, s.port3Out};
      else
         r = {1'b1, 8'h00};
      readReg = r;
   endfunction : readReg

   // ***********************************************
   // Input pin and counter channels
   // ***********************************************
   tin_sync u_tin_sync (
      .ref_clk (ref_clk),
      .rst     (rst),
      .pin     (timerInputPin),
      .level   (tinLevel),
      .fall    (tinFall)
   );

   // Divisor in bits 7:2, mode in 1:0
   assign firstCfg  = '{preValue:   st.firstPre[7:PRE_VAL_LO],
                        cntValue:   st.firstCnt,
                        continuous: st.firstPre[PRE_CONT]};
   assign secondCfg = '{preValue:   st.secondPre[7:PRE_VAL_LO],
                        cntValue:   st.secondCnt,
                        continuous: st.secondPre[PRE_CONT]};

   timer_channel u_first (
      .ref_clk (ref_clk),
      .rst     (rst),
      .tick    (prescTick),
      .load    (st.firstLoad),
      .run     (firstRun),
      .cfg     (firstCfg),
      .count   (firstCount),
      .eoc     (firstEoc)
   );

   timer_channel u_second (
      .ref_clk (ref_clk),
      .rst     (rst),
      .tick    (secondTick),
      .load    (secondLoadNow),
      .run     (secondRun),
      .cfg     (secondCfg),
      .count   (secondCount),
      .eoc     (secondEoc)
   );

   // ***********************************************
   // Source selection for the second counter
   // ***********************************************
   // Prescaler ticks once every four clocks
   assign prescTick = (st.div == DIV_LAST);
   assign extSrc    = ~st.secondPre[PRE_INTCLK];
   assign tinMode   = tin_mode_e'(st.mode[MODE_TIN_LO +: 2]);
   assign toutSel   = timer_output_pin_sel_e'(st.mode[MODE_TIMER_OUTPUT_PIN_LO +: 2]);
   assign firstRun  = st.mode[MODE_FIRST_EN];
   assign trigMode  = extSrc && (tinMode == TIN_ONESHOT || tinMode == TIN_RETRIG);

   // One-shot arms once; retrigger reloads each edge
   assign trigLoad = trigMode && st.mode[MODE_SECOND_EN] && tinFall
                     && (tinMode == TIN_RETRIG || !st.started);
   assign secondLoadNow = st.secondLoad | trigLoad;

   // Gate holds the prescaler; trigger modes wait for the arming edge
   always_comb
   begin
      secondRun  = 1'b0;
      secondTick = prescTick;
      if (st.mode[MODE_SECOND_EN])
      begin
         if (!extSrc)
            secondRun = 1'b1;
         else
         begin
            case (tinMode)
               TIN_EXT_CLK:
               begin
                  secondRun  = 1'b1;
                  secondTick = tinFall;
               end
               TIN_GATE:    secondRun = tinLevel;
               TIN_ONESHOT: secondRun = st.started;
               TIN_RETRIG:  secondRun = st.started;
               default:     secondRun = 1'b0;
            endcase
         end
      end
   end

   // ***********************************************
   // Next state: bus, registers, events, pin
   // ***********************************************
   always_comb
   begin
      logic       pinNext;
      logic [8:0] rd;
      logic [7:0] idx;
      pinNext = 1'b0;
      rd      = 9'h000;
      idx     = st.awAddr[9:2];
      next_st = st;

      // Pulses last one cycle
      next_st.firstLoad  = 1'b0;
      next_st.secondLoad = 1'b0;
      next_st.edgeReq    = tinFall;
      next_st.firstDone  = firstEoc;
      next_st.secondDone = secondEoc;
      next_st.div        = st.div + 2'h1;
      next_st.clkHalf    = ~st.clkHalf;

      // Arming cleared while second counter disabled
      if (!st.mode[MODE_SECOND_EN])
         next_st.started = 1'b0;
      else if (trigLoad)
         next_st.started = 1'b1;

      // End-of-count; a same-cycle write overrides below
      if (firstEoc)
      begin
         next_st.toutFirst = ~st.toutFirst;
         if (!st.firstPre[PRE_CONT])
            next_st.mode[MODE_FIRST_EN] = 1'b0;
      end
      if (secondEoc)
      begin
         next_st.toutSecond = ~st.toutSecond;
         if (!st.secondPre[PRE_CONT])
            next_st.mode[MODE_SECOND_EN] = 1'b0;
      end

      // Write address and data taken independently
      if (awvalid && st.awready)
      begin
         next_st.awHave = 1'b1;
         next_st.awAddr = awaddr;
      end
      if (wvalid && st.wready)
      begin
         next_st.wHave = 1'b1;
         next_st.wData = wdata[7:0];
         next_st.wLane = wstrb[0];
      end

      // Commit with both halves held, no response pending
      if (st.awHave && st.wHave && !st.bvalid)
      begin
         next_st.awHave = 1'b0;
         next_st.wHave  = 1'b0;
         next_st.bvalid = 1'b1;
         next_st.bresp  = RESP_OKAY;
         if (!addrOk(st.awAddr))
            next_st.bresp = RESP_SLVERR;
         else if (!st.wLane)
            next_st.bresp = RESP_OKAY;
         else if (idx == IDX_MODE)
         begin
            // Load bits are strobes, read back zero
            next_st.mode = st.wData & ~8'h05;
            next_st.firstLoad  = st.wData[MODE_FIRST_LOAD];
            next_st.secondLoad = st.wData[MODE_SECOND_LOAD];
            if (st.wData[MODE_FIRST_LOAD])
               next_st.toutFirst = 1'b1;
            if (st.wData[MODE_SECOND_LOAD])
               next_st.toutSecond = 1'b1;
         end
         else if (idx == IDX_FIRST_CNT)
            next_st.firstCnt = st.wData;
         else if (idx == IDX_SECOND_CNT)
            next_st.secondCnt = st.wData;
         else if (idx == IDX_FIRST_PRE)
            next_st.firstPre = st.wData;
         else if (idx == IDX_SECOND_PRE)
            next_st.secondPre = st.wData;
         else if (idx == IDX_PORT3)
            next_st.portData = st.wData;
         else
            next_st.bresp = RESP_SLVERR;
      end
      if (st.bvalid && bready)
         next_st.bvalid = 1'b0;
      next_st.awready = !next_st.awHave && !next_st.bvalid;
      next_st.wready  = !next_st.wHave && !next_st.bvalid;

      // Reads answer one cycle after the address is taken
      if (arvalid && st.arready)
      begin
         rd             = readReg(araddr[9:2], st, firstCount, secondCount);
         next_st.rvalid = 1'b1;
         next_st.rdata  = {24'h000000, rd[7:0]};
         next_st.rresp  = (rd[8] || !addrOk(araddr)) ? RESP_SLVERR : RESP_OKAY;
         if (!addrOk(araddr))
            next_st.rdata = 32'h00000000;
      end
      else if (st.rvalid && rready)
         next_st.rvalid = 1'b0;
      next_st.arready = !next_st.rvalid;

      // Timer output owns bit 6 unless switched off
      case (timer_output_pin_sel_e'(next_st.mode[MODE_TIMER_OUTPUT_PIN_LO +: 2]))
         TIMER_OUTPUT_PIN_FIRST:  pinNext = next_st.toutFirst;
         TIMER_OUTPUT_PIN_SECOND: pinNext = next_st.toutSecond;
         TIMER_OUTPUT_PIN_CLOCK:  pinNext = next_st.clkHalf;
         default:     pinNext = next_st.portData[PORT3_TIMER_OUTPUT_PIN_BIT];
      endcase
      next_st.port3Out = next_st.portData;
      next_st.port3Out[PORT3_TIMER_OUTPUT_PIN_BIT] = pinNext;
   end

   // ***********************************************
   // State register
   // ***********************************************
   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         st           <= '0;
         st.mode      <= MODE_RST;
         st.firstCnt  <= CNT_RST;
         st.secondCnt <= CNT_RST;
         st.firstPre  <= PRE_RST;
         st.secondPre <= PRE_RST;
         st.portData  <= PORT3_RST;
         st.port3Out  <= PORT3_RST;
         st.toutFirst  <= 1'b1;
         st.toutSecond <= 1'b1;
      end
      else
         st <= next_st;
   end

   // ***********************************************
   // Outputs straight from the state register
   // ***********************************************
   assign awready                  = st.awready;
   assign wready                   = st.wready;
   assign bvalid                   = st.bvalid;
   assign bresp                    = st.bresp;
   assign arready                  = st.arready;
   assign rvalid                   = st.rvalid;
   assign rdata                    = st.rdata;
   assign rresp                    = st.rresp;
   assign port3Out                 = st.port3Out;
   assign inputEdgeRequest         = st.edgeReq;
   assign firstCounterDoneRequest  = st.firstDone;
   assign secondCounterDoneRequest = st.secondDone;

endmodule : dual_timer_counter

// ==== logic/dual_timer_pkg.sv ====
package dual_timer_pkg;

   // ***********************************************
   // Bus geometry and register indices (byte = idx*4)
   // ***********************************************
   localparam int         ADDR_W         = 12;
   localparam logic [7:0] IDX_PORT3      = 8'h03;
   localparam logic [7:0] IDX_MODE       = 8'hF1;
   localparam logic [7:0] IDX_SECOND_CNT = 8'hF2;
   localparam logic [7:0] IDX_SECOND_PRE = 8'hF3;
   localparam logic [7:0] IDX_FIRST_CNT  = 8'hF4;
   localparam logic [7:0] IDX_FIRST_PRE  = 8'hF5;
   localparam logic [1:0] RESP_OKAY      = 2'h0;
   localparam logic [1:0] RESP_SLVERR    = 2'h2;

   // ***********************************************
   // Field positions and reset values
   // ***********************************************
   localparam int         MODE_FIRST_LOAD  = 0;
   localparam int         MODE_FIRST_EN    = 1;
   localparam int         MODE_SECOND_LOAD = 2;
   localparam int         MODE_SECOND_EN   = 3;
   localparam int         MODE_TIN_LO      = 4;
   localparam int         MODE_TIMER_OUTPUT_PIN_LO     = 6;
   localparam int         PRE_CONT         = 0;
   localparam int         PRE_INTCLK       = 1;
   localparam int         PRE_VAL_LO       = 2;
   localparam int         PORT3_TIMER_OUTPUT_PIN_BIT   = 6;
   localparam logic [7:0] MODE_RST         = 8'hC0;
   localparam logic [7:0] PRE_RST          = 8'h00;
   localparam logic [7:0] CNT_RST          = 8'h00;
   localparam logic [7:0] PORT3_RST        = 8'hFF;
   localparam logic [1:0] DIV_LAST         = 2'h3;

   // ***********************************************
   // Encodings
   // ***********************************************
   typedef enum logic [1:0] {TIN_EXT_CLK, TIN_GATE, TIN_ONESHOT, TIN_RETRIG} tin_mode_e;
   typedef enum logic [1:0] {TIMER_OUTPUT_PIN_FIRST, TIMER_OUTPUT_PIN_SECOND, TIMER_OUTPUT_PIN_CLOCK, TIMER_OUTPUT_PIN_OFF} timer_output_pin_sel_e;

   // ***********************************************
   // Carriers and state records
   // ***********************************************
   typedef struct packed {
      logic [5:0] preValue;
      logic [7:0] cntValue;
      logic       continuous;
   } chan_cfg_s;

   typedef struct packed {
      logic [5:0] pre;
      logic [7:0] cnt;
      logic       eoc;
   } chan_state_s;

   typedef struct packed {
      logic meta;
      logic level;
      logic prev;
   } sync_state_s;

   typedef struct packed {
      logic              awready;
      logic              wready;
      logic              arready;
      logic              bvalid;
      logic              rvalid;
      logic [1:0]        bresp;
      logic [1:0]        rresp;
      logic [31:0]       rdata;
      logic              awHave;
      logic              wHave;
      logic [ADDR_W-1:0] awAddr;
      logic [7:0]        wData;
      logic              wLane;
      logic [7:0]        mode;
      logic [7:0]        firstCnt;
      logic [7:0]        secondCnt;
      logic [7:0]        firstPre;
      logic [7:0]        secondPre;
      logic [7:0]        portData;
      logic              firstLoad;
      logic              secondLoad;
      logic [1:0]        div;
      logic              clkHalf;
      logic              toutFirst;
      logic              toutSecond;
      logic [7:0]        port3Out;
      logic              started;
      logic              edgeReq;
      logic              firstDone;
      logic              secondDone;
   } top_state_s;

endpackage : dual_timer_pkg

// ==== logic/timer_channel.sv ====
module timer_channel
   import dual_timer_pkg::*;
(
   input  wire logic       ref_clk,
   input  wire logic       rst,
   input  wire logic       tick,
   input  wire logic       load,
   input  wire logic       run,
   input  wire chan_cfg_s  cfg,
   output logic [7:0]      count,
   output logic            eoc
);

   chan_state_s st;
   chan_state_s next_st;

   // Zero wraps to the top of the field, giving 64 and 256
   always_comb
   begin
      next_st     = st;
      next_st.eoc = 1'b0;
      if (load)
      begin
         next_st.pre = cfg.preValue;
         next_st.cnt = cfg.cntValue;
      end
      else if (run && tick)
      begin
         if (st.pre == 6'h01)
         begin
            next_st.pre = cfg.preValue;
            if (st.cnt == 8'h01)
            begin
               next_st.eoc = 1'b1;
               next_st.cnt = cfg.cntValue;
            end
            else
               next_st.cnt = st.cnt - 8'h01;
         end
         else
            next_st.pre = st.pre - 6'h01;
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (rst)
         st <= '{pre: 6'h00, cnt: 8'h00, eoc: 1'b0};
      else
         st <= next_st;
   end

   assign count = st.cnt;
   assign eoc   = st.eoc;

endmodule : timer_channel

// ==== logic/tin_sync.sv ====
module tin_sync
   import dual_timer_pkg::*;
(
   input  wire logic ref_clk,
   input  wire logic rst,
   input  wire logic pin,
   output logic      level,
   output logic      fall
);

   sync_state_s st;
   sync_state_s next_st;

   // Two stages before use; edge detector sees only the second and third
   always_comb
   begin
      next_st.meta  = pin;
      next_st.level = st.meta;
      next_st.prev  = st.level;
   end

   always_ff @(posedge ref_clk)
   begin
      if (rst)
         st <= '{meta: 1'b1, level: 1'b1, prev: 1'b1};
      else
         st <= next_st;
   end

   assign level = st.level;
   assign fall  = st.prev & ~st.level;

endmodule : tin_sync
